/* File: design/ttc_core.sv */
// ttc_core: digital thermometer/thermostat core with three-wire serial port.
// assumes a sampled sensor word on sensor_temp in the clk domain; pins are asynchronous.
`default_nettype none

module ttc_core
    import ttc_pkg::*;
#(
    parameter int unsigned CONVERT_START_N_CYCLES_P = 32'(CONVERT_START_N_CYCLES)
) (
    input  wire logic               clk,
    input  wire logic               resetn,
    input  wire logic               clock_convert_pin,
    input  wire logic               frame_reset_n,
    input  wire logic               dq_in,
    output logic                    dq_out,
    output logic                    dq_oe,
    input  wire logic               cpu_mode,
    input  wire logic               one_shot_mode,
    input  wire logic [TEMP_W-1:0]  sensor_temp,
    output logic                    high_trip_out,
    output logic                    low_trip_out,
    output logic                    hysteresis_trip_out,
    output logic                    convert_start_n_done
);

    // pin synchronisers: clock/convert idles high, frame reset idles low
    logic [2:0] pins_sync;
    logic       sclk_s;
    logic       frame_s;
    logic       dq_s;

    ttc_sync #(
        .W      (3),
        .INIT   (3'h1)
    ) u_sync (
        .clk      (clk),
        .resetn   (resetn),
        .async_in ({dq_in, frame_reset_n, clock_convert_pin}),
        .sync_out (pins_sync)
    );

    assign sclk_s  = pins_sync[0];
    assign frame_s = pins_sync[1];
    assign dq_s    = pins_sync[2];

    // edge detection on the synchronised levels
    logic sclk_prev_q;
    logic frame_prev_q;
    logic sclk_rise;
    logic sclk_fall;
    logic frame_end;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sclk_prev_q  <= 1'b1;
            frame_prev_q <= 1'b0;
        end else begin
            sclk_prev_q  <= sclk_s;
            frame_prev_q <= frame_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_prev_q;
    assign sclk_fall = ~sclk_s & sclk_prev_q;
    assign frame_end = ~frame_s & frame_prev_q;

    // stand-alone convert control
    logic convert_start_n;
    logic standalone;
    logic sa_start;

    assign convert_start_n = sclk_s;
    assign standalone      = ~cpu_mode & ~frame_s;
    assign sa_start        = standalone & sclk_fall;

    // data registers
    logic [TEMP_W-1:0] measured_temp_value_q;
    logic [TEMP_W-1:0] upper_trip_point_q;
    logic [TEMP_W-1:0] lower_trip_point_q;

    // serial engine state
    ttc_ser_state_t     ser_state_q;
    logic [CNT_W-1:0]   bit_cnt_q;
    logic [CMD_W-1:0]   cmd_sr_q;
    logic [CMD_W-1:0]   cmd_q;
    logic [TEMP_W-1:0]  rd_sr_q;
    logic [TEMP_W-1:0]  wr_sr_q;
    logic [CMD_W-1:0]   cmd_next;
    logic               cmd_last;
    logic               host_start;
    logic               host_stop;

    assign cmd_next   = {dq_s, cmd_sr_q[CMD_W-1:1]};
    assign cmd_last   = (ser_state_q == SER_CMD) && frame_s && sclk_rise
                        && (bit_cnt_q == CNT_W'(CMD_W - 1));
    assign host_start = cmd_last && (cmd_next == CMD_START);
    assign host_stop  = cmd_last && (cmd_next == CMD_STOP);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ser_state_q <= SER_CMD;
            bit_cnt_q   <= '0;
            cmd_sr_q    <= '0;
            cmd_q       <= '0;
        end else if (!frame_s) begin
            ser_state_q <= SER_CMD;
            bit_cnt_q   <= '0;
        end else if (sclk_rise) begin
            case (ser_state_q)
                SER_CMD: begin
                    cmd_sr_q <= cmd_next;
                    if (cmd_last) begin
                        cmd_q     <= cmd_next;
                        bit_cnt_q <= '0;
                        case (cmd_next)
                            CMD_READ_TEMP, CMD_READ_UP, CMD_READ_LOW: begin
                                ser_state_q <= SER_READ;
                            end
                            CMD_WRITE_UP, CMD_WRITE_LOW: begin
                                ser_state_q <= SER_WRITE;
                            end
                            default: begin
                                ser_state_q <= SER_SKIP;
                            end
                        endcase
                    end else begin
                        bit_cnt_q <= bit_cnt_q + 1'b1;
                    end
                end
                SER_WRITE: begin
                    if (bit_cnt_q != '1) begin
                        bit_cnt_q <= bit_cnt_q + 1'b1;
                    end
                end
                SER_READ, SER_SKIP: begin
                    ser_state_q <= ser_state_q;
                end
                default: begin
                    ser_state_q <= SER_SKIP;
                end
            endcase
        end
    end

    // write capture: first nine bits kept, later bits dropped
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_sr_q <= '0;
        end else if (cmd_last) begin
            wr_sr_q <= '0;
        end else if (frame_s && sclk_rise && ser_state_q == SER_WRITE
                     && bit_cnt_q < CNT_W'(TEMP_W)) begin
            wr_sr_q[bit_cnt_q[3:0]] <= dq_s;
        end
    end

    logic write_commit;
    logic wrote_word;

    // a byte transfer spans only eight bits, so it never commits a limit
    assign wrote_word   = bit_cnt_q >= CNT_W'(TEMP_W);
    assign write_commit = frame_end && ser_state_q == SER_WRITE && wrote_word;

    // limit storage; factory values stand for the nonvolatile contents at reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            upper_trip_point_q <= UPPER_FACTORY;
            lower_trip_point_q <= LOWER_FACTORY;
        end else if (write_commit) begin
            if (cmd_q == CMD_WRITE_UP) begin
                upper_trip_point_q <= wr_sr_q;
            end else if (cmd_q == CMD_WRITE_LOW) begin
                lower_trip_point_q <= wr_sr_q;
            end
        end
    end

    // read path: load on decode, shift out on each falling edge
    logic [TEMP_W-1:0] rd_sel;

    always_comb begin
        case (cmd_next)
            CMD_READ_TEMP: rd_sel = measured_temp_value_q;
            CMD_READ_UP:   rd_sel = upper_trip_point_q;
            CMD_READ_LOW:  rd_sel = lower_trip_point_q;
            default:       rd_sel = '0;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_sr_q <= '0;
            dq_out  <= 1'b0;
        end else if (!frame_s) begin
            // line parks low between frames, even after a cut read
            dq_out  <= 1'b0;
        end else if (cmd_last) begin
            rd_sr_q <= rd_sel;
            dq_out  <= 1'b0;
        end else if (frame_s && sclk_fall && ser_state_q == SER_READ) begin
            dq_out  <= rd_sr_q[0];
            rd_sr_q <= {1'b0, rd_sr_q[TEMP_W-1:1]};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dq_oe <= 1'b0;
        end else begin
            dq_oe <= frame_s && ser_state_q == SER_READ && !cmd_last;
        end
    end

    // conversion control
    logic                   busy_q;
    logic                   host_run_q;
    logic [CONVERT_START_N_CNT_W-1:0]  convert_start_n_cnt_q;
    logic                   convert_start_n_finish;
    logic                   convert_start_n_start;
    logic                   repeat_convert_start_n;
    logic                   restart_q;

    assign convert_start_n_finish = busy_q && convert_start_n_cnt_q == CONVERT_START_N_CNT_W'(CONVERT_START_N_CYCLES_P - 1);
    // pin held low keeps converting and overrides one-shot
    assign repeat_convert_start_n = (standalone && !convert_start_n) || (host_run_q && !one_shot_mode);
    // one idle cycle between runs so convert_start_n_done marks every result
    assign convert_start_n_start  = sa_start || host_start || restart_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            restart_q <= 1'b0;
        end else begin
            restart_q <= convert_start_n_finish && repeat_convert_start_n;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            host_run_q <= 1'b0;
        end else if (host_stop || (convert_start_n_finish && one_shot_mode)) begin
            host_run_q <= 1'b0;
        end else if (host_start) begin
            host_run_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_q     <= 1'b0;
            convert_start_n_cnt_q <= '0;
        end else if (convert_start_n_start && !busy_q) begin
            busy_q     <= 1'b1;
            convert_start_n_cnt_q <= '0;
        end else if (convert_start_n_finish) begin
            busy_q     <= 1'b0;
            convert_start_n_cnt_q <= '0;
        end else if (busy_q) begin
            convert_start_n_cnt_q <= convert_start_n_cnt_q + 1'b1;
        end
    end

    assign convert_start_n_done = ~busy_q;

    // result clamp to the measurable range
    logic [TEMP_W-1:0] clamped;

    always_comb begin
        if ($signed(sensor_temp) < $signed(TEMP_MIN)) begin
            clamped = TEMP_MIN;
        end else if ($signed(sensor_temp) > $signed(TEMP_MAX)) begin
            clamped = TEMP_MAX;
        end else begin
            clamped = sensor_temp;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            measured_temp_value_q <= TEMP_RESET;
        end else if (convert_start_n_finish) begin
            measured_temp_value_q <= clamped;
        end
    end

    // trips compare the freshly loaded result one cycle after the finish
    logic trip_update_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            trip_update_q <= 1'b0;
        end else begin
            trip_update_q <= convert_start_n_finish;
        end
    end

    ttc_trip u_trip (
        .clk                 (clk),
        .resetn              (resetn),
        .update              (trip_update_q),
        .temp                (measured_temp_value_q),
        .upper_limit         (upper_trip_point_q),
        .lower_limit         (lower_trip_point_q),
        .high_trip_out       (high_trip_out),
        .low_trip_out        (low_trip_out),
        .hysteresis_trip_out (hysteresis_trip_out)
    );

endmodule : ttc_core

`default_nettype wire

/* File: design/ttc_pkg.sv */
// ttc_pkg: constants shared by the thermometer/thermostat core and its helpers.
// assumes a single 100 MHz system clock.
`default_nettype none

package ttc_pkg;

    // data word layout
    localparam int          TEMP_W         = 9;
    localparam int          CMD_W          = 8;
    localparam int          CNT_W          = 5;

    // reset and factory values
    localparam logic [8:0]  TEMP_RESET     = 9'h188;
    localparam logic [8:0]  UPPER_FACTORY  = 9'h01E;
    localparam logic [8:0]  LOWER_FACTORY  = 9'h014;

    // measurement range, half-degree steps
    localparam logic [8:0]  TEMP_MIN       = 9'h192;
    localparam logic [8:0]  TEMP_MAX       = 9'h0FA;

    // serial command codes
    localparam logic [7:0]  CMD_READ_TEMP  = 8'h11;
    localparam logic [7:0]  CMD_WRITE_UP   = 8'h21;
    localparam logic [7:0]  CMD_WRITE_LOW  = 8'h22;
    localparam logic [7:0]  CMD_READ_UP    = 8'h31;
    localparam logic [7:0]  CMD_READ_LOW   = 8'h32;
    localparam logic [7:0]  CMD_START      = 8'h41;
    localparam logic [7:0]  CMD_STOP       = 8'h42;

    // conversion time
    localparam longint      CLK_HZ         = 100_000_000;
    localparam longint      CONVERT_START_N_TIME_MS   = 750;
    localparam longint      CONVERT_START_N_CYCLES    = (CONVERT_START_N_TIME_MS * CLK_HZ) / 1000;
    localparam int          CONVERT_START_N_CNT_W     = 27;

    typedef enum logic [1:0] {
        SER_CMD,
        SER_READ,
        SER_WRITE,
        SER_SKIP
    } ttc_ser_state_t;

endpackage : ttc_pkg

`default_nettype wire

/* File: design/ttc_sync.sv */
// ttc_sync: three-flop synchronisers for pin inputs, one lane per bit.
// assumes the inputs are asynchronous to clk; output moves once stages 2 and 3 agree.
`default_nettype none

module ttc_sync
    import ttc_pkg::*;
#(
    parameter int       W         = 3,
    parameter logic [2:0] INIT    = 3'h0
) (
    input  wire logic           clk,
    input  wire logic           resetn,
    input  wire logic [W-1:0]   async_in,
    output var  logic [W-1:0]   sync_out
);

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_lane
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic out_q;
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    s1_q  <= INIT[i];
                    s2_q  <= INIT[i];
                    s3_q  <= INIT[i];
                    out_q <= INIT[i];
                end else begin
                    s1_q <= async_in[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        out_q <= s3_q;
                    end
                end
            end
            assign sync_out[i] = out_q;
        end
    endgenerate

endmodule : ttc_sync

`default_nettype wire

/* File: design/ttc_trip.sv */
// ttc_trip: thermostat comparators and trip output registers.
// assumes update is a one-cycle pulse at the end of each conversion.
`default_nettype none

module ttc_trip
    import ttc_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               resetn,
    input  wire logic               update,
    input  wire logic [TEMP_W-1:0]  temp,
    input  wire logic [TEMP_W-1:0]  upper_limit,
    input  wire logic [TEMP_W-1:0]  lower_limit,
    output logic                    high_trip_out,
    output logic                    low_trip_out,
    output logic                    hysteresis_trip_out
);

    logic at_or_above;
    logic at_or_below;

    assign at_or_above = $signed(temp) >= $signed(upper_limit);
    assign at_or_below = $signed(temp) <= $signed(lower_limit);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            high_trip_out <= 1'b0;
            low_trip_out  <= 1'b0;
        end else if (update) begin
            high_trip_out <= at_or_above;
            low_trip_out  <= at_or_below;
        end
    end

    // set wins when both limits are met at once
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hysteresis_trip_out <= 1'b0;
        end else if (update) begin
            if (at_or_above) begin
                hysteresis_trip_out <= 1'b1;
            end else if (at_or_below) begin
                hysteresis_trip_out <= 1'b0;
            end
        end
    end

endmodule : ttc_trip

`default_nettype wire

/* File: test/testbench.sv */
// testbench: self-checking bench for ttc_core with a behavioural host.
// assumes a 100 MHz clock and a shortened conversion length.
`default_nettype none
module testbench
    import ttc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CONVERT_START_N = 20;
    logic              clk, resetn, pin, frame_n, dq_in, dq_out, dq_oe;
    logic              cpu_mode, one_shot_mode, convert_start_n_done, hyst_q;
    logic              high_trip_out, low_trip_out, hysteresis_trip_out;
    logic [TEMP_W-1:0] sensor_temp;
    int                error_cnt = 0;
    int                checked = 0;
    initial clk = 1'b0;
    always #5 clk = ~clk;
    ttc_core #(.CONVERT_START_N_CYCLES_P(CONVERT_START_N)) u_ttc_core (
        .clk(clk), .resetn(resetn), .clock_convert_pin(pin), .frame_reset_n(frame_n),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .cpu_mode(cpu_mode),
        .one_shot_mode(one_shot_mode), .sensor_temp(sensor_temp),
        .high_trip_out(high_trip_out), .low_trip_out(low_trip_out),
        .hysteresis_trip_out(hysteresis_trip_out), .convert_start_n_done(convert_start_n_done));
    ttc_host u_host (.clk(clk), .dq_out(dq_out), .dq_oe(dq_oe),
        .clock_convert_pin(pin), .frame_reset_n(frame_n), .dq_in(dq_in));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report
    function automatic logic [8:0] clamp(input logic [8:0] s);
        if ($signed(s) < $signed(TEMP_MIN))
            return TEMP_MIN;
        if ($signed(s) > $signed(TEMP_MAX))
            return TEMP_MAX;
        return s;
    endfunction : clamp
    task automatic wr(input logic [7:0] cmd, input logic [15:0] v, input int n);
        logic [15:0] r;
        u_host.xfer(cmd, 1'b1, v, n, r);
    endtask : wr
    // sixteen clocks: nine data bits then seven trailing zeros
    task automatic rd9(input logic [7:0] cmd, input logic [8:0] exp);
        logic [15:0] r;
        u_host.xfer(cmd, 1'b0, 16'h0000, 16, r);
        check(r, {7'h00, exp});
    endtask : rd9
    task automatic wait_convert_start_n;
        int k;
        k = 0;
        while (convert_start_n_done !== 1'b0 && k < 16) begin
            @(negedge clk);
            k++;
        end
        k = 0;
        while (convert_start_n_done !== 1'b1 && k < CONVERT_START_N + 8) begin
            @(negedge clk);
            k++;
        end
        check({15'h0000, convert_start_n_done}, 16'h0001);
        repeat (3) @(negedge clk);
    endtask : wait_convert_start_n
    task automatic count_busy(input int cycles, output int n);
        n = 0;
        repeat (cycles) begin
            @(negedge clk);
            n += int'(convert_start_n_done !== 1'b1);
        end
    endtask : count_busy
    task automatic convert(input logic [8:0] s, input logic [8:0] up, input logic [8:0] lo);
        logic [8:0] t;
        t = clamp(s);
        sensor_temp = s;
        u_host.pulse(8);
        wait_convert_start_n();
        if ($signed(t) >= $signed(up))
            hyst_q = 1'b1;
        else if ($signed(t) <= $signed(lo))
            hyst_q = 1'b0;
        check({13'h0000, high_trip_out, low_trip_out, hysteresis_trip_out},
              {13'h0000, $signed(t) >= $signed(up), $signed(t) <= $signed(lo), hyst_q});
        rd9(CMD_READ_TEMP, t);
    endtask : convert
    initial begin
        repeat (100000) @(posedge clk); // far beyond the expected run
        error_cnt++;
        final_report();
    end
    initial begin
        logic [8:0] up, lo;
        logic [15:0] r16;
        int         n;
        resetn = 1'b0;
        cpu_mode = 1'b0;
        one_shot_mode = 1'b0;
        sensor_temp = 9'h000;
        hyst_q = 1'b0;
        void'($urandom(26));
        repeat (16) @(negedge clk);
        resetn = 1'b1;
        repeat (8) @(negedge clk);
        check({13'h0000, high_trip_out, low_trip_out, hysteresis_trip_out}, 16'h0000);
        rd9(CMD_READ_TEMP, TEMP_RESET);
        rd9(CMD_READ_UP, UPPER_FACTORY);
        rd9(CMD_READ_LOW, LOWER_FACTORY);
        u_host.xfer(CMD_READ_TEMP, 1'b0, 16'h0000, 9, r16);
        check(r16, {7'h00, TEMP_RESET});
        $display("test reset done");
        up = 9'($urandom_range(0, 40));
        lo = 9'($urandom_range(0, 40));
        wr(CMD_WRITE_UP, {7'h00, up}, 9);
        wr(CMD_WRITE_LOW, {7'h00, lo}, 16);
        wr(CMD_WRITE_UP, 16'h00FF, 8);
        rd9(CMD_READ_UP, up);
        rd9(CMD_READ_LOW, lo);
        $display("test write done");
        for (int j = 0; j < 4; j++) begin
            up = 9'($urandom_range(0, 40));
            lo = 9'($urandom_range(0, 40));
            wr(CMD_WRITE_UP, {7'h00, up}, 9);
            wr(CMD_WRITE_LOW, {7'h00, lo}, 9);
            convert(up, up, lo);
            convert(lo, up, lo);
            for (int i = 0; i < 5; i++)
                convert(9'($urandom_range(0, 60)) - 9'h005, up, lo);
        end
        convert(9'h100, up, lo);
        convert(9'h0FF, up, lo);
        $display("test convert done");
        cpu_mode = 1'b1;
        u_host.pulse(8);
        count_busy(40, n);
        check(16'(n), 16'h0000);
        one_shot_mode = 1'b1;
        sensor_temp = 9'h032;
        wr(CMD_START, 16'h0000, 0);
        wait_convert_start_n();
        rd9(CMD_READ_TEMP, 9'h032);
        one_shot_mode = 1'b0;
        wr(CMD_START, 16'h0000, 0);
        count_busy(4 * CONVERT_START_N, n);
        check({15'h0000, n > 3 * CONVERT_START_N}, 16'h0001);
        wr(CMD_STOP, 16'h0000, 0);
        repeat (CONVERT_START_N + 4) @(negedge clk);
        count_busy(40, n);
        check(16'(n), 16'h0000);
        $display("test host done");
        final_report();
    end
endmodule : testbench
`default_nettype wire

/* File: test/ttc_chk.sv */
// ttc_chk: port assertions for ttc_core, bound to every instance.
// assumes one clock domain and the hand-over conversion timing.
`default_nettype none
module ttc_chk
    import ttc_pkg::*;
#(
    parameter int unsigned CONVERT_START_N_CYCLES_P = 20
) (
    input wire logic              clk,
    input wire logic              resetn,
    input wire logic              clock_convert_pin,
    input wire logic              frame_reset_n,
    input wire logic              dq_in,
    input wire logic              dq_out,
    input wire logic              dq_oe,
    input wire logic              cpu_mode,
    input wire logic              one_shot_mode,
    input wire logic [TEMP_W-1:0] sensor_temp,
    input wire logic              high_trip_out,
    input wire logic              low_trip_out,
    input wire logic              hysteresis_trip_out,
    input wire logic              convert_start_n_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] busy_cnt_q;
    // cycles spent in the running conversion
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            busy_cnt_q <= 32'h0;
        else if (convert_start_n_done)
            busy_cnt_q <= 32'h0;
        else
            busy_cnt_q <= busy_cnt_q + 32'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_trip_on_done: assert property (
        $changed({high_trip_out, low_trip_out, hysteresis_trip_out}) |-> $past(convert_start_n_done))
        else $error("trip output moved away from a conversion end");
    a_hyst_on_high: assert property (high_trip_out |-> hysteresis_trip_out)
        else $error("high trip without hysteresis trip");
    a_hyst_clear: assert property (
        low_trip_out && !high_trip_out |-> !hysteresis_trip_out)
        else $error("hysteresis trip held at the lower limit");
    a_convert_start_n_bound: assert property (busy_cnt_q <= CONVERT_START_N_CYCLES_P + 1)
        else $error("conversion ran past its length");
    a_pin_start: assert property (
        !cpu_mode && !frame_reset_n && convert_start_n_done && $fell(clock_convert_pin)
        |-> ##[1:8] !convert_start_n_done) else $error("convert pin fall started nothing");
    a_oe_rise: assert property ($rose(dq_oe) |-> frame_reset_n)
        else $error("data driven outside a frame");
    a_oe_release: assert property (!frame_reset_n [*8] |-> !dq_oe)
        else $error("data still driven after frame end");
    a_dq_quiet: assert property ($changed(dq_out) |-> dq_oe || $past(dq_oe))
        else $error("data line moved while not driven");
endmodule : ttc_chk
bind ttc_core ttc_chk #(.CONVERT_START_N_CYCLES_P(CONVERT_START_N_CYCLES_P)) u_ttc_chk (
    .clk(clk), .resetn(resetn), .clock_convert_pin(clock_convert_pin),
    .frame_reset_n(frame_reset_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .cpu_mode(cpu_mode), .one_shot_mode(one_shot_mode), .sensor_temp(sensor_temp),
    .high_trip_out(high_trip_out), .low_trip_out(low_trip_out),
    .hysteresis_trip_out(hysteresis_trip_out), .convert_start_n_done(convert_start_n_done));
`default_nettype wire

/* File: test/ttc_host.sv */
// ttc_host: behavioural three-wire host for the core's serial port.
// assumes the core samples its pins through synchronisers.
`default_nettype none
module ttc_host #(
    parameter int HALF = 8
) (
    input  wire logic clk,
    input  wire logic dq_out,
    input  wire logic dq_oe,
    output var  logic clock_convert_pin,
    output var  logic frame_reset_n,
    output var  logic dq_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        clock_convert_pin = 1'b1;
        frame_reset_n = 1'b0;
        dq_in = 1'b0;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle
    // released data line toggles; an undriven line reads as garbage
    task automatic xfer(input logic [7:0] cmd, input logic wr, input logic [15:0] wd,
                        input int n, output logic [15:0] rd);
        rd = 16'h0;
        frame_reset_n = 1'b1;
        idle(HALF);
        for (int i = 0; i < 8 + n; i++) begin
            clock_convert_pin = 1'b0;
            if (i < 8)
                dq_in = cmd[i];
            else if (wr)
                dq_in = wd[i-8];
            else
                dq_in = ~dq_in;
            idle(HALF);
            if (i >= 8 && !wr)
                rd[i-8] = dq_oe ? dq_out : ~dq_out;
            clock_convert_pin = 1'b1;
            idle(HALF);
        end
        frame_reset_n = 1'b0;
        dq_in = ~dq_in;
        idle(2 * HALF);
    endtask : xfer
    task automatic pulse(input int n);
        clock_convert_pin = 1'b0;
        idle(n);
        clock_convert_pin = 1'b1;
    endtask : pulse
endmodule : ttc_host
`default_nettype wire
